// file: hdl/frebw_pkg.sv
/*
  Shared constants for the flash row erase / block write sequencer:
  register indices, control bit positions, unlock bytes and timing.
  Assumes an 8-bit register port from the core and a 250 MHz mclk.
*/
package frebw_pkg;
    // Register indices on the core-side port
    localparam logic [2:0] REG_ADDR_LOW  = 3'h0;
    localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
    localparam logic [2:0] REG_DATA_LOW  = 3'h2;
    localparam logic [2:0] REG_DATA_HIGH = 3'h3;
    localparam logic [2:0] REG_CONTROL   = 3'h4;
    localparam logic [2:0] REG_UNLOCK    = 3'h5;
    // Bit positions inside mem_control
    localparam int CTL_WR         = 1;
    localparam int CTL_WRITE_EN   = 2;
    localparam int CTL_FREE       = 4;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_CFG_SEL    = 6;
    localparam int CTL_PGMS       = 7;
    // Unlock bytes, in the order they must arrive
    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    // Array geometry
    localparam int         WORD_W      = 14;
    localparam int         HIGH_W      = 6;
    localparam int         ADDR_W      = 8 + HIGH_W;
    localparam int         LATCH_COUNT = 16;
    localparam logic [13:0] LATCH_RESET = 14'h3FFF;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    // Write protection limits: everything below the limit is locked
    localparam logic [13:0] WP_QUARTER_TOP = 14'h0200;
    localparam logic [13:0] WP_HALF_TOP    = 14'h0400;
    // Timing
    localparam int MCLK_PERIOD_NS = 4;
    localparam int OP_TIME_MS     = 2;
    localparam int OP_CYCLES_DEF  = (OP_TIME_MS * 1000000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CYCLES_PER_INSTR = 1;
    localparam int SETUP_INSTR      = 2;
    localparam int SETUP_CYCLES     = SETUP_INSTR * CYCLES_PER_INSTR;
endpackage

// file: hdl/frebw_if.sv
/*
  Link between the core-side end and the flash sequencer.
  Assumes both ends share mclk; the core end is the only master.
*/
`timescale 1ns/1ps
interface frebw_if;
    logic       wr_stb;      // One-cycle register write
    logic       rd_stb;      // One-cycle register read
    logic [2:0] reg_addr;    // Register index
    logic [7:0] wdata;       // Write data
    logic [7:0] rdata;       // Read data, cycle after rd_stb
    logic       core_stall;  // Core halted while flash is busy

    modport core
    (
        output wr_stb, rd_stb, reg_addr, wdata,
        input  rdata, core_stall
    );
    modport dev
    (
        input  wr_stb, rd_stb, reg_addr, wdata,
        output rdata, core_stall
    );
endinterface

// file: hdl/frebw_core_end.sv
/*
  Core-side end: forwards software register accesses onto the link,
  squashes the two slots after a write-start (they behave as no-ops)
  and holds interrupts off across the unlock sequence.
  Assumes software drives one strobe per cycle on mclk.
*/
`timescale 1ns/1ps
module frebw_core_end
    import frebw_pkg::*;
(
    input  wire logic       mclk,      // Core clock
    input  wire logic       rst_b,     // Sync reset, active low
    input  wire logic [2:0] sw_addr,   // Software register index
    input  wire logic [7:0] sw_wdata,  // Software write data
    input  wire logic       sw_wr,     // Software write strobe
    input  wire logic       sw_rd,     // Software read strobe
    output logic      [7:0] sw_rdata,  // Read data, cycle after sw_rd
    output logic            core_halt, // Core not executing this cycle
    output logic            int_hold,  // Global interrupts forced off
    frebw_if.core           bus        // Link to the sequencer
);
    logic [1:0] slot_q;
    logic       squash;
    logic       start_wr;

    // Slots after write-start and the flash stall both swallow accesses
    assign squash    = (slot_q != 2'd0) || bus.core_stall;
    assign core_halt = squash;
    assign start_wr  = sw_wr && !squash && sw_addr == REG_CONTROL && sw_wdata[CTL_WR];

    // Link strobes are gated, never delayed, so the slave never waits
    assign bus.wr_stb   = sw_wr && !squash;
    assign bus.rd_stb   = sw_rd && !squash;
    assign bus.reg_addr = sw_addr;
    assign bus.wdata    = sw_wdata;
    assign sw_rdata     = bus.rdata;

    // Two squashed slots follow any write-start
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            slot_q <= 2'd0;
        else if (start_wr)
            slot_q <= 2'(SETUP_CYCLES);
        else if (slot_q != 2'd0)
            slot_q <= slot_q - 2'd1;
    end

    // Interrupts held from the first unlock byte until the sequence ends
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            int_hold <= 1'b0;
        else if (sw_wr && !squash && sw_addr == REG_UNLOCK && sw_wdata == UNLOCK_FIRST)
            int_hold <= 1'b1;
        else if ((sw_wr || sw_rd) && !squash && sw_addr != REG_UNLOCK)
            int_hold <= 1'b0;
    end
endmodule

// file: hdl/frebw_device.sv
/*
  Flash self-programming sequencer: address, data and control
  registers, unlock checker, sixteen write latches, row erase and
  block program with core stall.
  Assumes the flash macro accepts one-cycle erase/program pulses with
  address and block data held steady until op_busy falls.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
// How it works
// - Erase only whole rows, addressed by registers.
// - Software sets up select bits before unlocking.
// - 55h then AAh, then write-start begins.
// - Write-start bit stays set until erase ends.
// - Two setup cycles before the core stalls.
// - Software places two no-ops after write-start.
// - Erase stalls core 2 ms, clocks keep running.
// - Core resumes at third instruction afterward.
// - Programming never erases anything by itself.
// - Sixteen latches, aligned block, no crossing.
// - Latches preset to 3FFFh after programming.
// - Latch-only set: load one latch only.
// - Latch-only clear: load last, program block.
// - Whole latch block is always programmed.
// - Latch loads never stall the core.
// - Program stalls core 2 ms, final word only.
// - Software increments address between latch loads.
// - No interrupt inside the unlock sequence.
// - Each latch holds one 14-bit data word.
// - Write-start refused unless write-enable set.
// - Protected segments are never erased or programmed.
`timescale 1ns/1ps
module frebw_device
    import frebw_pkg::*;
#(
    parameter int OP_CYCLES = OP_CYCLES_DEF, // Stall length of erase/program
    parameter int LATCHES   = LATCH_COUNT    // Write latches per block
)
(
    input  wire logic                      mclk,          // Core clock
    input  wire logic                      rst_b,         // Sync reset, active low
    frebw_if.dev                           bus,           // Core register link
    input  wire logic [1:0]                write_protect_field, // Protection setting
    output logic                           flash_erase,   // Row erase pulse
    output logic                           flash_program, // Block program pulse
    output logic [ADDR_W-1:0]              flash_addr,    // Row/block base address
    output logic [LATCHES*WORD_W-1:0]      flash_block,   // Latch contents, entry 0 low
    output logic                           op_busy        // Flash operation running
);
    localparam int IDX_W = $clog2(LATCHES);
    localparam int CNT_W = $clog2(OP_CYCLES + 1);

    typedef enum logic [1:0] {UL_IDLE = 2'b00, UL_GOT1 = 2'b01, UL_ARMED = 2'b10} frebw_ul_t;
    typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_SETUP = 2'b01, SQ_STALL = 2'b10} frebw_sq_t;
    typedef enum logic [1:0] {OP_LATCH = 2'b00, OP_PROG = 2'b01, OP_ERASE = 2'b10} frebw_op_t;

    frebw_ul_t          unlock_q;
    frebw_sq_t          seq_q;
    frebw_op_t          op_q;
    logic [7:0]         addr_low_q;
    logic [HIGH_W-1:0]  addr_high_q;
    logic [7:0]         data_low_q;
    logic [HIGH_W-1:0]  data_high_q;
    logic               cfg_sel_q;
    logic               pgms_q;
    logic               free_q;
    logic               latch_only_q;
    logic               write_en_q;
    logic               wr_q;
    logic [1:0]         setup_q;
    logic [CNT_W-1:0]   busy_q;
    logic [7:0]         rdata_q;
    logic [WORD_W-1:0]  latch_q [LATCHES];
    logic [ADDR_W-1:0]  addr_full;
    logic               any_acc;
    logic               ul_wr;
    logic               ctl_wr;
    logic               wp_hit;
    logic               start_ok;
    logic               prog_done;

    assign addr_full = {addr_high_q, addr_low_q};
    assign any_acc   = bus.wr_stb || bus.rd_stb;
    assign ul_wr     = bus.wr_stb && bus.reg_addr == REG_UNLOCK;
    assign ctl_wr    = bus.wr_stb && bus.reg_addr == REG_CONTROL;

    // Protection check; 2'b11 leaves the whole array open
    always_comb
    begin
        unique case (write_protect_field)
            2'b11:   wp_hit = 1'b0;
            2'b10:   wp_hit = addr_full < WP_QUARTER_TOP;
            2'b01:   wp_hit = addr_full < WP_HALF_TOP;
            2'b00:   wp_hit = 1'b1;
        endcase
    end

    // Start needs the armed unlock, write-enable, program space, no lock
    assign start_ok = ctl_wr && bus.wdata[CTL_WR] && unlock_q == UL_ARMED
                      && write_en_q
                      && !cfg_sel_q && pgms_q && !wp_hit
                      && seq_q == SQ_IDLE;
    assign prog_done = seq_q == SQ_STALL && busy_q == '0 && op_q == OP_PROG;

    // Unlock tracker: any other access in between disarms it
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            unlock_q <= UL_IDLE;
        else if (any_acc)
        begin
            if (ul_wr && bus.wdata == UNLOCK_FIRST)
                unlock_q <= UL_GOT1;
            else if (ul_wr && bus.wdata == UNLOCK_SECOND && unlock_q == UL_GOT1)
                unlock_q <= UL_ARMED;
            else
                unlock_q <= UL_IDLE;
        end
    end

    // Address and data register pairs
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            addr_low_q  <= RESET_BYTE;
            addr_high_q <= '0;
            data_low_q  <= RESET_BYTE;
            data_high_q <= '0;
        end
        else if (bus.wr_stb)
        begin
            if (bus.reg_addr == REG_ADDR_LOW)
                addr_low_q <= bus.wdata;
            if (bus.reg_addr == REG_ADDR_HIGH)
                addr_high_q <= bus.wdata[HIGH_W-1:0];
            if (bus.reg_addr == REG_DATA_LOW)
                data_low_q <= bus.wdata;
            if (bus.reg_addr == REG_DATA_HIGH)
                data_high_q <= bus.wdata[HIGH_W-1:0];
        end
    end

    // Software control bits; write-enable is never cleared by hardware
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cfg_sel_q    <= 1'b0;
            pgms_q       <= 1'b0;
            free_q       <= 1'b0;
            latch_only_q <= 1'b0;
            write_en_q   <= 1'b0;
        end
        else if (ctl_wr)
        begin
            cfg_sel_q    <= bus.wdata[CTL_CFG_SEL];
            pgms_q       <= bus.wdata[CTL_PGMS];
            free_q       <= bus.wdata[CTL_FREE];
            latch_only_q <= bus.wdata[CTL_LATCH_ONLY];
            write_en_q   <= bus.wdata[CTL_WRITE_EN];
        end
    end

    // Sequencer: setup slots, then stall for erase or program
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            seq_q   <= SQ_IDLE;
            op_q    <= OP_LATCH;
            wr_q    <= 1'b0;
            setup_q <= 2'd0;
            busy_q  <= '0;
        end
        else
        begin
            unique case (seq_q)
                SQ_IDLE:
                begin
                    if (start_ok)
                    begin
                        seq_q   <= SQ_SETUP;
                        wr_q    <= 1'b1;
                        setup_q <= 2'(SETUP_CYCLES - 1);
                        if (free_q)
                            op_q <= OP_ERASE;
                        else if (latch_only_q)
                            op_q <= OP_LATCH;
                        else
                            op_q <= OP_PROG;
                    end
                end
                SQ_SETUP:
                begin
                    if (setup_q != 2'd0)
                        setup_q <= setup_q - 2'd1;
                    else if (op_q == OP_LATCH)
                    begin
                        seq_q <= SQ_IDLE;
                        wr_q  <= 1'b0;
                    end
                    else
                    begin
                        seq_q  <= SQ_STALL;
                        busy_q <= CNT_W'(OP_CYCLES - 1);
                    end
                end
                SQ_STALL:
                begin
                    if (busy_q != '0)
                        busy_q <= busy_q - 1'b1;
                    else
                    begin
                        seq_q <= SQ_IDLE;
                        wr_q  <= 1'b0;
                    end
                end
                default:
                    seq_q <= SQ_IDLE;
            endcase
        end
    end

    // Only the stall phase halts the core; clocks keep running
    assign bus.core_stall = seq_q == SQ_STALL;
    assign op_busy        = seq_q != SQ_IDLE;

    // Flash pulses fire as the stall begins; program never implies erase
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            flash_erase   <= 1'b0;
            flash_program <= 1'b0;
            flash_addr    <= '0;
        end
        else
        begin
            flash_erase   <= seq_q == SQ_SETUP && setup_q == 2'd0 && op_q == OP_ERASE;
            flash_program <= seq_q == SQ_SETUP && setup_q == 2'd0 && op_q == OP_PROG;
            if (start_ok)
                flash_addr <= {addr_full[ADDR_W-1:IDX_W], IDX_W'(0)};
        end
    end

    // Write latches: load on start, preset after a block program
    for (genvar i = 0; i < LATCHES; i++)
    begin : g_latch
        always_ff @(posedge mclk)
        begin
            if (!rst_b)
                latch_q[i] <= LATCH_RESET;
            else if (prog_done)
                latch_q[i] <= LATCH_RESET;
            else if (start_ok && !free_q && addr_low_q[IDX_W-1:0] == IDX_W'(i))
                latch_q[i] <= {data_high_q, data_low_q};
        end
        // The whole block goes out, loaded or not
        assign flash_block[i*WORD_W +: WORD_W] = latch_q[i];
    end

    // Read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            rdata_q <= RESET_BYTE;
        else if (bus.rd_stb)
        begin
            unique case (bus.reg_addr)
                REG_ADDR_LOW:  rdata_q <= addr_low_q;
                REG_ADDR_HIGH: rdata_q <= {2'b00, addr_high_q};
                REG_DATA_LOW:  rdata_q <= data_low_q;
                REG_DATA_HIGH: rdata_q <= {2'b00, data_high_q};
                REG_CONTROL:   rdata_q <= {pgms_q, cfg_sel_q, latch_only_q, free_q, 1'b0,
                                           write_en_q, wr_q, 1'b0};
                default:       rdata_q <= RESET_BYTE;
            endcase
        end
    end
    assign bus.rdata = rdata_q;
endmodule

// file: dv/frebw_props.sv
/*
  Concurrent checks on the link between the core end and the sequencer,
  and on the sequencer's flash-side outputs.
  Assumes one clock (mclk) and a sync active-low reset; instantiated by tb_top.
*/
`timescale 1ns/1ps
module frebw_props
    import frebw_pkg::*;
#(
    parameter int OP_CYCLES = 20, // Stall length in cycles
    parameter int LATCHES   = 16  // Write latches per block
)
(
    input wire logic                      mclk,          // Core clock
    input wire logic                      rst_b,         // Sync reset, active low
    input wire logic                      wr_stb,        // Link write strobe
    input wire logic [2:0]                reg_addr,      // Link register index
    input wire logic [7:0]                wdata,         // Link write data
    input wire logic                      core_stall,    // Core halted
    input wire logic                      flash_erase,   // Erase pulse
    input wire logic                      flash_program, // Program pulse
    input wire logic [ADDR_W-1:0]         flash_addr,    // Block base address
    input wire logic [LATCHES*WORD_W-1:0] flash_block,   // Latch contents
    input wire logic                      op_busy        // Sequencer busy
);
    logic        u55;
    logic        uaa;
    logic        go;
    logic [31:0] stall_cnt_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Link writes that make up the start sequence
    assign u55 = wr_stb && reg_addr == REG_UNLOCK && wdata == UNLOCK_FIRST;
    assign uaa = wr_stb && reg_addr == REG_UNLOCK && wdata == UNLOCK_SECOND;
    assign go  = wr_stb && reg_addr == REG_CONTROL && wdata[CTL_WR];

    // Stall length counter; a repetition would be far too long to unroll
    always_ff @(posedge mclk)
    begin
        if (!rst_b || !core_stall)
            stall_cnt_q <= 32'h0000_0000;
        else
            stall_cnt_q <= stall_cnt_q + 32'h0000_0001;
    end

    chk_stall_has_op: assert property ($rose(core_stall) |-> flash_erase || flash_program)
        else $error("stall began without a flash operation");
    chk_setup_two: assert property ($rose(core_stall) |-> $past(go, 3))
        else $error("stall did not follow start write by three cycles");
    chk_unlock_order: assert property ($rose(core_stall) |-> $past(uaa, 4) && $past(u55, 5))
        else $error("stall without ordered unlock bytes");
    chk_stall_length: assert property ($fell(core_stall) |-> stall_cnt_q == OP_CYCLES)
        else $error("stall length wrong");
    chk_stall_bound: assert property (core_stall |-> stall_cnt_q < OP_CYCLES)
        else $error("stall overran its length");
    chk_pulse_aligned: assert property (flash_erase || flash_program |->
        core_stall && flash_addr[3:0] == 4'h0)
        else $error("flash pulse unaligned or outside stall");
    chk_pulse_single: assert property (flash_erase || flash_program |=>
        !flash_erase && !flash_program)
        else $error("flash pulse longer than one cycle");
    chk_hold_block: assert property (core_stall && $past(core_stall) |->
        $stable(flash_addr) && $stable(flash_block))
        else $error("address or block moved during stall");
    chk_busy_stall: assert property ($rose(core_stall) |-> $past(op_busy)
        && $past(op_busy, 2) && !$past(op_busy, 3))
        else $error("stall not preceded by exactly two busy setup cycles");
    chk_no_erase_prog: assert property (flash_program |-> !flash_erase)
        else $error("program pulse came with an erase");

    cover property (flash_erase);
    cover property (flash_program);
    cover property (go ##3 !op_busy);
endmodule

// file: dv/tb_top.sv
/*
  Self-checking bench: software accesses drive the core end, which reaches
  the sequencer over the link. Assumes a 4 ns mclk and a shortened stall.
*/
`timescale 1ns/1ps
module tb_top;
    import frebw_pkg::*;
    localparam int         OPC       = 20;    // Shortened flash operation time
    localparam logic [7:0] CTL_ERASE = 8'h94; // Program memory, erase, write enable
    localparam logic [1:0]  WP_TAB [3] = '{2'b10, 2'b00, 2'b01};
    localparam logic [13:0] AD_TAB [3] = '{14'h01F0, 14'h3F00, 14'h0400};
    localparam int          NE_TAB [3] = '{1, 1, 2};
    logic              mclk;
    logic              rst_b;
    logic              sw_wr;
    logic              sw_rd;
    logic [2:0]        sw_addr;
    logic [7:0]        sw_wdata;
    logic [7:0]        sw_rdata;
    logic              core_halt;
    logic              int_hold;
    logic [1:0]        wp_field;
    logic              flash_erase;
    logic              flash_program;
    logic              op_busy;
    logic [ADDR_W-1:0] flash_addr;
    logic [ADDR_W-1:0] cap_addr;
    logic [223:0]      flash_block;
    logic [223:0]      cap_blk;
    logic [223:0]      exp_blk;
    int                err_count;
    int                compares;
    int                n_erase;
    int                n_prog;
    int                n_stall;
    int                cyc;

    frebw_if bus ();
    frebw_core_end i_frebw_core_end
    (
        .mclk(mclk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .core_halt(core_halt),
        .int_hold(int_hold), .bus(bus)
    );
    frebw_device #(.OP_CYCLES(OPC)) i_frebw_device
    (
        .mclk(mclk), .rst_b(rst_b), .bus(bus), .write_protect_field(wp_field),
        .flash_erase(flash_erase), .flash_program(flash_program),
        .flash_addr(flash_addr), .flash_block(flash_block), .op_busy(op_busy)
    );
    frebw_props #(.OP_CYCLES(OPC), .LATCHES(LATCH_COUNT)) i_frebw_props
    (
        .mclk(mclk), .rst_b(rst_b), .wr_stb(bus.wr_stb), .reg_addr(bus.reg_addr),
        .wdata(bus.wdata), .core_stall(bus.core_stall), .flash_erase(flash_erase),
        .flash_program(flash_program), .flash_addr(flash_addr),
        .flash_block(flash_block), .op_busy(op_busy)
    );

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // Count flash pulses and stall cycles; cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (bus.core_stall)
            n_stall++;
        if (flash_erase)
        begin
            n_erase++;
            cap_addr = flash_addr;
        end
        if (flash_program)
        begin
            n_prog++;
            cap_addr = flash_addr;
            cap_blk  = flash_block;
        end
        if (cyc == 3000)
        begin
            err_count++;
            stop_test();
        end
    end

    // One register access, launched just after an edge, taken at the next
    task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        sw_wr    <= w;
        sw_rd    <= r;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge mclk);
    endtask

    task automatic chk(input string nm, input logic [223:0] seen, input logic [223:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        acc(1'b0, 1'b1, a, 8'h00);
        #1;
        chk(nm, 224'(sw_rdata), 224'(e));
    endtask

    // Idle until the squashed slots and any stall are over
    task automatic wait_done();
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        repeat (60)
        begin
            @(posedge mclk);
            #1;
            if (!core_halt && !op_busy)
                break;
        end
        @(posedge mclk);
    endtask

    // Upper data bits set on purpose: only six may be kept
    task automatic setad(input logic [13:0] ad, input logic [13:0] d);
        acc(1'b1, 1'b0, REG_ADDR_LOW, ad[7:0]);
        acc(1'b1, 1'b0, REG_ADDR_HIGH, {2'b00, ad[13:8]});
        acc(1'b1, 1'b0, REG_DATA_LOW, d[7:0]);
        acc(1'b1, 1'b0, REG_DATA_HIGH, {2'b11, d[13:8]});
    endtask

    // Select bits first, then unlock; brk slips a read into the sequence
    // A write in the first slot after write-start must be swallowed
    task automatic start(input logic [7:0] ctl, input logic brk);
        acc(1'b1, 1'b0, REG_CONTROL, ctl);
        acc(1'b1, 1'b0, REG_UNLOCK, UNLOCK_FIRST);
        if (brk)
            acc(1'b0, 1'b1, REG_CONTROL, 8'h00);
        acc(1'b1, 1'b0, REG_UNLOCK, UNLOCK_SECOND);
        chk("interrupt hold", 224'(int_hold), 224'(!brk));
        acc(1'b1, 1'b0, REG_CONTROL, ctl | 8'h02);
        acc(1'b1, 1'b0, REG_ADDR_LOW, 8'hFF);
        wait_done();
    endtask

    task automatic stop_test();
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        mclk     = 1'b0;
        rst_b    = 1'b0;
        sw_wr    = 1'b0;
        sw_rd    = 1'b0;
        sw_addr  = 3'h0;
        sw_wdata = 8'h00;
        wp_field = 2'b11;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        chk("reset latches", flash_block, {16{LATCH_RESET}});
        rd(REG_CONTROL, 8'h00, "reset control");
        setad(14'h0A37, 14'h0000);
        start(8'h90, 1'b0);
        start(CTL_ERASE, 1'b1);
        chk("refused erase", 224'(n_erase), 224'h0);
        start(CTL_ERASE, 1'b0);
        chk("erase count", 224'(n_erase), 224'h1);
        chk("erase row", 224'(cap_addr), 224'h0A30);
        chk("erase stall", 224'(n_stall), 224'(OPC));
        rd(REG_CONTROL, CTL_ERASE, "control after erase");
        rd(REG_ADDR_LOW, 8'h37, "squashed write");
        for (int i = 0; i < 3; i++)
        begin
            wp_field <= WP_TAB[i];
            setad(AD_TAB[i], 14'h0000);
            start(CTL_ERASE, 1'b0);
            chk("protected erase", 224'(n_erase), 224'(NE_TAB[i]));
        end
        wp_field <= 2'b11;
        setad(14'h0120, 14'h2ABC);
        start(8'hA4, 1'b0);
        setad(14'h0125, 14'h1234);
        start(8'hA4, 1'b0);
        exp_blk          = {16{LATCH_RESET}};
        exp_blk[13:0]    = 14'h2ABC;
        exp_blk[83:70]   = 14'h1234;
        chk("latch load", flash_block, exp_blk);
        chk("load stall", 224'(n_stall + n_prog), 224'(OPC * 2));
        setad(14'h012F, 14'h3001);
        start(8'h84, 1'b0);
        exp_blk[223:210] = 14'h3001;
        chk("program block", cap_blk, exp_blk);
        chk("program base", 224'(cap_addr), 224'h0120);
        chk("latch preset", flash_block, {16{LATCH_RESET}});
        chk("program erase", 224'(n_erase), 224'h2);
        chk("program stall", 224'(n_stall), 224'(OPC * 3));
        stop_test();
    end
endmodule
